/* File: logic/iprr_map.svh */
/*
  Register map and constants of the interrupt priority resolver.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef IPRR_MAP_SVH
`define IPRR_MAP_SVH

`define IPRR_NUM_SRC 54
`define IPRR_VEC_OFFSET 6'h08
// byte offsets on the bus
`define IPRR_FLAG_BASE 12'h000
`define IPRR_FLAGCLR_BASE 12'h010
`define IPRR_ENABLE_BASE 12'h020
`define IPRR_LEVEL_BASE 12'h040
`define IPRR_CORE_PRIO 12'h080
`define IPRR_RESULT 12'h084
`define IPRR_IRQ_STAT 12'h088
`define IPRR_IRQ_CLR 12'h08C
`define IPRR_IRQ_EN 12'h090
`define IPRR_NUM_FLAG_REGS 4
`define IPRR_NUM_LEVEL_REGS 14
`define IPRR_LEVEL_RESET 16'h4444
`define IPRR_NIB_MASK 16'h7777
// implemented sources: 0..25, 39, 40, 43
`define IPRR_SRC_PRESENT 54'h0_0980_03FF_FFFF
// sources present on the larger variant only: 19, 20, 24, 25
`define IPRR_SRC_LARGE_ONLY 54'h0_0000_0318_0000

`endif

/* File: logic/iprr_pkg.sv */
/*
  Types of the interrupt priority resolver.
  Assumes the map header is on the include path.
*/
`include "iprr_map.svh"
package iprr_pkg;
  typedef logic [`IPRR_NUM_SRC-1:0] iprr_src_vec_t;
  typedef struct packed {
    logic valid;
    logic [2:0] level;
    logic [5:0] vector;
  } iprr_result_t;
endpackage : iprr_pkg

/* File: logic/iprr_resolver.sv */
/*
  Interrupt priority resolver with request flags, enables, levels and an AHB-Lite slave.
  Assumes one 10 MHz clock, source events as one-cycle or level inputs synchronous to it.
*/
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "iprr_map.svh"
//
// Overview of operation
// - each source has a three-bit level in low bits of its nibble, four per register
// - nibble bit three ignores writes and reads zero
// - levels compare numerically, seven highest, zero lowest
// - source number breaks ties only among equal pending levels
// - source zero ranks highest, fifty-three lowest
// - tie rank equals source number, lowest number wins
// - vector equals source number plus eight
// - sources zero to fifteen are the fixed first peripheral set
// - sources sixteen to twenty-five fixed, some only on larger variant
// - sources 39, 40, 43 are period match, position, fault A
// - assigned level dominates natural order
// - level zero source is never a candidate
// - request flag sets regardless of enable
// - pending flag arbitrates only while enabled
module iprr_resolver
  import iprr_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [`IPRR_NUM_SRC-1:0] SRC_EVENT_I,
  input wire logic HSEL_I,
  input wire logic [11:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic WIN_VALID_O,
  output logic [2:0] WIN_LEVEL_O,
  output logic [5:0] WIN_VECTOR_O,
  output logic CORE_TAKE_O,
  output logic IRQ_O
);

  // ****************************************
  // source population
  // ****************************************
  localparam iprr_src_vec_t SRC_MASK = LARGE_VARIANT ? iprr_src_vec_t'(`IPRR_SRC_PRESENT) :
    iprr_src_vec_t'(`IPRR_SRC_PRESENT) & ~iprr_src_vec_t'(`IPRR_SRC_LARGE_ONLY);

  // ****************************************
  // bus address phase capture
  // ****************************************
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic rd_go;
  logic wr_go;
  assign rd_go = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
  assign wr_go = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= wr_go;
      if (wr_go) begin
        wr_addr_reg <= HADDR_I;
      end
    end
  end

  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base,
                                   input int n);
    in_bank = (a >= base) && (a < base + 12'(4 * n)) && (a[1:0] == 2'b00);
  endfunction : in_bank

  function automatic logic [3:0] word_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    word_idx = d[5:2];
  endfunction : word_idx

  // ****************************************
  // request flags, enables, levels
  // ****************************************
  iprr_src_vec_t flag_reg;
  iprr_src_vec_t enable_reg;
  logic [15:0] level_reg [`IPRR_NUM_LEVEL_REGS];
  logic [2:0] core_prio_reg;
  iprr_src_vec_t clr_mask;
  iprr_src_vec_t en_wr_mask;
  iprr_src_vec_t wdata_rep;

  always_comb begin
    clr_mask = '0;
    en_wr_mask = '0;
    wdata_rep = '0;
    for (int i = 0; i < `IPRR_NUM_SRC; i++) begin
      wdata_rep[i] = HWDATA_I[i % 16];
      if (wr_pend_reg && in_bank(wr_addr_reg, `IPRR_FLAGCLR_BASE, `IPRR_NUM_FLAG_REGS) &&
          word_idx(wr_addr_reg, `IPRR_FLAGCLR_BASE) == 4'(i / 16)) begin
        clr_mask[i] = HWDATA_I[i % 16];
      end
      if (wr_pend_reg && in_bank(wr_addr_reg, `IPRR_ENABLE_BASE, `IPRR_NUM_FLAG_REGS) &&
          word_idx(wr_addr_reg, `IPRR_ENABLE_BASE) == 4'(i / 16)) begin
        en_wr_mask[i] = 1'b1;
      end
    end
  end

  // set wins over clear; enable plays no part here
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= ((flag_reg & ~clr_mask) | SRC_EVENT_I) & SRC_MASK;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      enable_reg <= '0;
    end else begin
      enable_reg <= ((enable_reg & ~en_wr_mask) | (wdata_rep & en_wr_mask)) & SRC_MASK;
    end
  end

  generate
    for (genvar g = 0; g < `IPRR_NUM_LEVEL_REGS; g++) begin : g_lvl
      always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          level_reg[g] <= `IPRR_LEVEL_RESET;
        end else if (wr_pend_reg && in_bank(wr_addr_reg, `IPRR_LEVEL_BASE, `IPRR_NUM_LEVEL_REGS)
                     && word_idx(wr_addr_reg, `IPRR_LEVEL_BASE) == 4'(g)) begin
          level_reg[g] <= HWDATA_I[15:0] & `IPRR_NIB_MASK;
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      core_prio_reg <= 3'h0;
    end else if (wr_pend_reg && wr_addr_reg == `IPRR_CORE_PRIO) begin
      core_prio_reg <= HWDATA_I[2:0];
    end
  end

  // ****************************************
  // arbitration
  // ****************************************
  iprr_result_t win;
  always_comb begin
    logic [2:0] lv;
    lv = 3'h0;
    win = '0;
    // descending scan so the lowest number wins a tie
    for (int i = `IPRR_NUM_SRC - 1; i >= 0; i--) begin
      lv = level_reg[i / 4][(i % 4) * 4 +: 3];
      if (flag_reg[i] && enable_reg[i] && SRC_MASK[i] && lv != 3'h0 &&
          lv >= win.level) begin
        win.valid = 1'b1;
        win.level = lv;
        win.vector = 6'(i) + `IPRR_VEC_OFFSET;
      end
    end
  end

  assign WIN_VALID_O = win.valid;
  assign WIN_LEVEL_O = win.level;
  assign WIN_VECTOR_O = win.vector;
  assign CORE_TAKE_O = win.valid && (win.level > core_prio_reg);

  // ****************************************
  // interrupt status
  // ****************************************
  logic irq_stat_reg;
  logic irq_en_reg;
  logic irq_clr;
  assign irq_clr = wr_pend_reg && wr_addr_reg == `IPRR_IRQ_CLR && HWDATA_I[0];

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat_reg <= 1'b0;
    end else begin
      irq_stat_reg <= CORE_TAKE_O || (irq_stat_reg && !irq_clr);
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_en_reg <= 1'b0;
    end else if (wr_pend_reg && wr_addr_reg == `IPRR_IRQ_EN) begin
      irq_en_reg <= HWDATA_I[0];
    end
  end

  assign IRQ_O = irq_stat_reg && irq_en_reg;

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rd_next;
  always_comb begin
    rd_next = 32'h0000_0000;
    for (int i = 0; i < `IPRR_NUM_SRC; i++) begin
      if (in_bank(HADDR_I, `IPRR_FLAG_BASE, `IPRR_NUM_FLAG_REGS) &&
          word_idx(HADDR_I, `IPRR_FLAG_BASE) == 4'(i / 16)) begin
        rd_next[i % 16] = flag_reg[i];
      end
      if (in_bank(HADDR_I, `IPRR_ENABLE_BASE, `IPRR_NUM_FLAG_REGS) &&
          word_idx(HADDR_I, `IPRR_ENABLE_BASE) == 4'(i / 16)) begin
        rd_next[i % 16] = enable_reg[i];
      end
    end
    if (in_bank(HADDR_I, `IPRR_LEVEL_BASE, `IPRR_NUM_LEVEL_REGS)) begin
      rd_next[15:0] = level_reg[word_idx(HADDR_I, `IPRR_LEVEL_BASE)];
    end
    if (HADDR_I == `IPRR_CORE_PRIO) begin
      rd_next[2:0] = core_prio_reg;
    end
    if (HADDR_I == `IPRR_RESULT) begin
      rd_next[9:0] = win;
    end
    if (HADDR_I == `IPRR_IRQ_STAT) begin
      rd_next[0] = irq_stat_reg;
    end
    if (HADDR_I == `IPRR_IRQ_EN) begin
      rd_next[0] = irq_en_reg;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (rd_go) begin
      HRDATA_O <= rd_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  // candidate levels seen, for the dominance check
  logic [7:0] cand_lvl;
  always_comb begin
    logic [2:0] cl;
    cl = 3'h0;
    cand_lvl = 8'h00;
    for (int i = 0; i < `IPRR_NUM_SRC; i++) begin
      cl = level_reg[i / 4][(i % 4) * 4 +: 3];
      if (flag_reg[i] && enable_reg[i] && SRC_MASK[i]) begin
        cand_lvl[cl] = 1'b1;
      end
    end
  end

  level_dominates_a: assert property (WIN_VALID_O ? ((cand_lvl >> WIN_LEVEL_O) == 8'h01) :
    (cand_lvl[7:1] == 7'h00))
    else $error("winner not at highest candidate level");
  flag_sets_event_a: assert property ((SRC_EVENT_I & SRC_MASK) != '0 |=>
    ((flag_reg & $past(SRC_EVENT_I & SRC_MASK)) == $past(SRC_EVENT_I & SRC_MASK)))
    else $error("event lost from request flag");
  absent_never_set_a: assert property ((flag_reg & ~SRC_MASK) == '0)
    else $error("absent source flagged");
  vector_range_a: assert property (WIN_VALID_O |-> WIN_VECTOR_O >= 6'h08 &&
    WIN_VECTOR_O <= 6'h3D)
    else $error("vector out of range");
  winner_enabled_a: assert property (WIN_VALID_O |->
    (flag_reg[WIN_VECTOR_O - 6'h08] && enable_reg[WIN_VECTOR_O - 6'h08]))
    else $error("winner not pending and enabled");
  winner_level_a: assert property (WIN_VALID_O |->
    level_reg[(WIN_VECTOR_O - 6'h08) / 4][((WIN_VECTOR_O - 6'h08) % 4) * 4 +: 3] == WIN_LEVEL_O)
    else $error("winner level mismatch");
  no_zero_level_a: assert property (WIN_VALID_O |-> WIN_LEVEL_O != 3'h0)
    else $error("level zero presented");
  none_pending_a: assert property ((flag_reg & enable_reg) == '0 |-> !WIN_VALID_O)
    else $error("valid with nothing pending");
  take_compare_a: assert property (CORE_TAKE_O |-> WIN_LEVEL_O > core_prio_reg)
    else $error("take without higher level");
  generate
    for (genvar g = 0; g < `IPRR_NUM_LEVEL_REGS; g++) begin : g_top
      top_bit_zero_a: assert property ((level_reg[g] & ~`IPRR_NIB_MASK) == 16'h0000)
        else $error("nibble top bit set");
    end
  endgenerate
  irq_sticky_a: assert property (CORE_TAKE_O |=> irq_stat_reg)
    else $error("status not set");

  win_seen_c: cover property (WIN_VALID_O ##1 !WIN_VALID_O);
  take_seen_c: cover property (CORE_TAKE_O);
  irq_seen_c: cover property (IRQ_O);
  tie_seen_c: cover property ($countones(flag_reg & enable_reg) > 1 && WIN_VALID_O);
  levels_compete_c: cover property (WIN_VALID_O && $countones(cand_lvl[7:1]) > 1);

endmodule : iprr_resolver

/* File: verif/iprr_core_model.sv */
/*
  Behavioural core that takes the winning request.
  Assumes the resolver's winner outputs and the core's own priority level.
*/
`timescale 1ns/1ps
module iprr_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic win_valid_i,
  input wire logic [2:0] win_level_i,
  input wire logic [5:0] win_vector_i,
  input wire logic [2:0] core_prio_i,
  output logic accept_o,
  output logic [5:0] taken_vector_o
);
  // only a strictly higher level gets in
  assign accept_o = win_valid_i && (win_level_i > core_prio_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      taken_vector_o <= 6'h00;
    end else if (accept_o) begin
      taken_vector_o <= win_vector_i;
    end
  end
endmodule : iprr_core_model

/* File: verif/iprr_resolver_tb.sv */
/*
  Self-checking bench of the resolver, with a core model on the winner side.
  Assumes the design files and the core model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module iprr_resolver_tb;
  import iprr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  iprr_src_vec_t ev = '0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, w_valid, take, irq, m_take;
  logic [2:0] w_level;
  logic [2:0] prio = 3'h0;
  logic [5:0] w_vector, m_vector;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int src[5] = '{0, 25, 39, 40, 43};
  always #50 clk = ~clk;
  iprr_resolver i_dut (.SYS_CLK_I(clk), .RST_I(rst), .SRC_EVENT_I(ev), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .WIN_VALID_O(w_valid), .WIN_LEVEL_O(w_level),
    .WIN_VECTOR_O(w_vector), .CORE_TAKE_O(take), .IRQ_O(irq));
  iprr_core_model i_core (.clk_i(clk), .rst_i(rst), .win_valid_i(w_valid),
    .win_level_i(w_level), .win_vector_i(w_vector), .core_prio_i(prio),
    .accept_o(m_take), .taken_vector_o(m_vector));
  // **********
  // bus and event tasks
  // **********
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus
  task automatic fire(input iprr_src_vec_t bits);
    @(posedge clk);
    ev <= bits;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask : fire
  task automatic clr();
    for (int k = 0; k < 4; k++) bus(1'b1, 12'h010 + 12'(4 * k), 32'h0000FFFF);
  endtask : clr
  task automatic en_all(input logic [31:0] v);
    for (int k = 0; k < 4; k++) bus(1'b1, 12'h020 + 12'(4 * k), v);
  endtask : en_all
  // **********
  // scenarios
  // **********
  task automatic t_regs();
    bus(1'b0, 12'h040, 32'h0);
    `CHK(rd, 32'h00004444)
    `CHK(hresp, 1'b0)
    bus(1'b1, 12'h074, 32'hFFFFFFFF);
    bus(1'b0, 12'h074, 32'h0);
    `CHK(rd, 32'h00007777)
    bus(1'b0, 12'h0F0, 32'h0);
    `CHK(rd, 32'h00000000)
  endtask : t_regs
  task automatic t_tie();
    en_all(32'h0000FFFF);
    fire(54'h28);
    `CHK(w_vector, 6'h0B)
    `CHK(w_level, 3'h4)
    bus(1'b1, 12'h044, 32'h00004464);
    `CHK(w_vector, 6'h0D)
    `CHK(w_level, 3'h6)
    bus(1'b1, 12'h044, 32'h00004404);
    `CHK(w_vector, 6'h0B)
    fire(54'h1 | (54'h1 << 43));
    `CHK(w_vector, 6'h08)
    clr();
    bus(1'b1, 12'h044, 32'h00004444);
  endtask : t_tie
  task automatic t_table();
    foreach (src[i]) begin
      fire(54'h1 << src[i]);
      `CHK(w_vector, 6'(src[i] + 8))
      clr();
    end
    fire(54'h1 << 26);
    `CHK(w_valid, 1'b0)
    bus(1'b0, 12'h004, 32'h0);
    `CHK(rd, 32'h00000000)
  endtask : t_table
  task automatic t_mask();
    en_all(32'h0);
    fire(54'h1 << 9);
    bus(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h00000200)
    `CHK(w_valid, 1'b0)
    bus(1'b1, 12'h020, 32'h00000200);
    `CHK(w_vector, 6'h11)
    clr();
  endtask : t_mask
  task automatic t_core();
    en_all(32'h0000FFFF);
    bus(1'b1, 12'h08C, 32'h1);
    bus(1'b1, 12'h090, 32'h1);
    prio <= 3'h4;
    bus(1'b1, 12'h080, 32'h4);
    fire(54'h4);
    `CHK(take, 1'b0)
    `CHK(irq, 1'b0)
    prio <= 3'h3;
    bus(1'b1, 12'h080, 32'h3);
    `CHK(take, m_take)
    `CHK(take, 1'b1)
    `CHK(m_vector, 6'h0A)
    clr();
    `CHK(irq, 1'b1)
    bus(1'b0, 12'h088, 32'h0);
    `CHK(rd, 32'h00000001)
    bus(1'b1, 12'h08C, 32'h1);
    `CHK(irq, 1'b0)
    bus(1'b1, 12'h090, 32'h0);
    fire(54'h4);
    `CHK(irq, 1'b0)
    bus(1'b1, 12'h090, 32'h1);
    `CHK(irq, 1'b1)
  endtask : t_core
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_tie();
    t_table();
    t_mask();
    t_core();
    finish_test();
  end
endmodule : iprr_resolver_tb
